// >>> bench/testbench.sv
// Self-checking bench for the serial receive error, interrupt and wake block
`timescale 1ns/1ns
module testbench import urxw_pkg::*;;
  typedef struct packed {
    logic [3:0] cfg;
    logic ad;
    logic gie;
    logic stk;
    logic [8:0] w;
    logic bp;
    logic [1:0] ls;
    logic [1:0] ef;
    logic [1:0] ni;
    logic [1:0] nc;
  } urxw_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pclk = 1'b1;
  logic brk = 1'b0;
  logic ade = 1'b0;
  logic wk = 1'b0;
  logic rie = 1'b1;
  logic gie = 1'b1;
  logic stk = 1'b0;
  logic te_en = 1'b0;
  logic ti_en = 1'b0;
  logic tx_e = 1'b0;
  logic tx_i = 1'b0;
  logic sa = 1'b0;
  logic dr = 1'b0;
  urxw_cfg_t cfg = '0;
  logic rx_line;
  logic rxp;
  urxw_status_t st;
  logic [8:0] data;
  logic irq_n;
  logic core;
  logic wake;
  int errors = 0;
  int num_checks = 0;
  int n_irq = 0;
  int n_core = 0;
  int n_wake = 0;
  int cyc = 0;
  int bi;
  int bc;
  int bw;
  urxw_row_t r;
  // Parity rows keep address detect off, so the two features are checked apart
  urxw_row_t rows[12] = '{
    '{4'h0, 1'b0, 1'b1, 1'b0, 9'h0a5, 1'b0, 2'h0, 2'h0, 2'h1, 2'h1},
    '{4'h8, 1'b0, 1'b1, 1'b0, 9'h15a, 1'b0, 2'h0, 2'h0, 2'h1, 2'h1},
    '{4'h4, 1'b0, 1'b1, 1'b0, 9'h037, 1'b0, 2'h0, 2'h0, 2'h1, 2'h1},
    '{4'h6, 1'b0, 1'b1, 1'b0, 9'h0c3, 1'b1, 2'h0, 2'h1, 2'h1, 2'h1},
    '{4'h1, 1'b0, 1'b1, 1'b0, 9'h055, 1'b0, 2'h2, 2'h2, 2'h1, 2'h1},
    '{4'h0, 1'b0, 1'b1, 1'b0, 9'h0f0, 1'b0, 2'h1, 2'h2, 2'h1, 2'h1},
    '{4'h0, 1'b1, 1'b1, 1'b0, 9'h07f, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0},
    '{4'h0, 1'b1, 1'b1, 1'b0, 9'h080, 1'b0, 2'h0, 2'h0, 2'h1, 2'h1},
    '{4'h8, 1'b1, 1'b1, 1'b0, 9'h0ff, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0},
    '{4'h8, 1'b1, 1'b1, 1'b0, 9'h100, 1'b0, 2'h0, 2'h0, 2'h1, 2'h1},
    '{4'h0, 1'b0, 1'b0, 1'b0, 9'h011, 1'b0, 2'h0, 2'h0, 2'h1, 2'h0},
    '{4'h0, 1'b0, 1'b1, 1'b1, 9'h022, 1'b0, 2'h0, 2'h0, 2'h1, 2'h0}
  };
  assign rxp = rx_line & ~brk;
  urxw_serial_src urxw_serial_src_inst (.clk(clk), .rx_line(rx_line));
  urxw_top urxw_top_inst (
    .clk(clk), .reset(reset), .port_clk_on(pclk), .rx_pin(rxp), .port_mode_select(1'b1),
    .port_enable_bit(1'b1), .receiver_enable(1'b1), .serial_control_one(cfg), .addr_detect_enable(ade),
    .rx_wake_enable(wk), .rx_irq_enable(rie), .tx_empty_irq_enable(te_en), .tx_idle_irq_enable(ti_en),
    .tx_empty(tx_e), .tx_idle(tx_i), .global_irq_enable(gie), .serial_unit_irq_enable(1'b1),
    .stack_full(stk), .baud_divisor_reg(8'h00), .status_access(sa), .data_read(dr),
    .serial_status_reg(st), .tx_rx_data_reg(data), .irq_pulse_n(irq_n), .core_irq(core), .wake_req(wake)
  );
  initial forever #2 clk = ~clk;
  // One-cycle outputs are counted here so tests compare totals, not edges
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq_n === 1'b0)
      n_irq <= n_irq + 1;
    if (core === 1'b1)
      n_core <= n_core + 1;
    if (wake === 1'b1)
      n_wake <= n_wake + 1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Status access first, then the data read
  task automatic rd();
    sa <= 1'b1;
    @(posedge clk);
    sa <= 1'b0;
    dr <= 1'b1;
    @(posedge clk);
    dr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : rd
  task automatic wait_avail();
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      if (st.rx_available_flag === 1'b1)
        break;
    end
    repeat (3) @(posedge clk);
  endtask : wait_avail
  task automatic test_done();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check(st, 6'h20);
    check({data, irq_n, core, wake}, 12'h004);
    foreach (rows[i]) begin
      r = rows[i];
      cfg <= r.cfg;
      ade <= r.ad;
      gie <= r.gie;
      stk <= r.stk;
      bi = n_irq;
      bc = n_core;
      urxw_serial_src_inst.send(r.cfg, r.w, r.bp, r.ls);
      wait_avail();
      check({st.framing_error_flag, st.parity_error_flag}, r.ef);
      check(data, r.w);
      check(n_irq - bi, r.ni);
      check(n_core - bc, r.nc);
      rd();
      check({st.rx_available_flag, data}, 10'h000);
    end
    for (int k = 0; k < 4; k++) begin
      {te_en, ti_en} <= k[1:0];
      @(posedge clk);
      bi = n_irq;
      tx_e <= 1'b1;
      repeat (4) @(posedge clk);
      tx_i <= 1'b1;
      repeat (4) @(posedge clk);
      check(n_irq - bi, k[1] + k[0]);
      tx_e <= 1'b0;
      tx_i <= 1'b0;
      @(posedge clk);
    end
    bi = n_irq;
    for (int k = 1; k < 4; k++)
      urxw_serial_src_inst.send(4'h0, k[8:0], 1'b0, 2'h0);
    repeat (8) @(posedge clk);
    check({st.overrun_flag, data}, 10'h201);
    check(n_irq - bi, 3);
    dr <= 1'b1;
    @(posedge clk);
    dr <= 1'b0;
    repeat (3) @(posedge clk);
    check(data, 9'h001);
    rd();
    check({st.overrun_flag, data}, 10'h002);
    rd();
    check(st.rx_available_flag, 1'b0);
    rie <= 1'b0;
    bi = n_irq;
    urxw_serial_src_inst.send(4'h0, 9'h0aa, 1'b0, 2'h1);
    wait_avail();
    check(n_irq - bi, 0);
    check(st.framing_error_flag, 1'b1);
    rd();
    // One low sample in the middle of data bit 0 marks the word noisy but keeps its value
    fork
      urxw_serial_src_inst.send(4'h0, 9'h0ff, 1'b0, 2'h0);
      begin
        repeat (26) @(posedge clk);
        brk <= 1'b1;
        @(posedge clk);
        brk <= 1'b0;
      end
    join
    wait_avail();
    check({st.noise_flag, st.framing_error_flag, data}, 11'h4ff);
    rd();
    check(st.noise_flag, 1'b0);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check({st, data}, 15'h4000);
    rie <= 1'b1;
    wk <= 1'b1;
    gie <= 1'b0;
    // Reception is finished before the port clock is stopped
    urxw_serial_src_inst.send(4'h0, 9'h03c, 1'b0, 2'h0);
    wait_avail();
    pclk <= 1'b0;
    @(posedge clk);
    rd();
    check({st.rx_available_flag, data}, 10'h23c);
    bi = n_irq;
    bc = n_core;
    bw = n_wake;
    brk <= 1'b1;
    repeat (3) @(posedge clk);
    brk <= 1'b0;
    repeat (3) @(posedge clk);
    check(n_wake - bw, 1);
    pclk <= 1'b1;
    urxw_serial_src_inst.send(4'h0, 9'h00f, 1'b0, 2'h0);
    repeat (600) @(posedge clk);
    check(n_irq - bi, 0);
    repeat (400) @(posedge clk);
    check(n_irq - bi, 1);
    check(n_core - bc, 0);
    rd();
    check({st.rx_available_flag, data}, 10'h000);
    test_done();
  end
endmodule : testbench

// >>> bench/urxw_serial_src.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/1ns
module urxw_serial_src import urxw_pkg::*; (
  input wire logic clk,
  output logic rx_line
);
  // The bench runs divisor 0: one sample tick a clock, 16 clocks a bit
  localparam int BIT_CLKS = 16;
  initial rx_line = 1'b1;
  task automatic put(input logic b);
    rx_line <= b;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : put
  // Frames go out LSB first; bad_par and low_stop corrupt a frame only when a test asks for it
  task automatic send(input urxw_cfg_t cfg, input logic [8:0] w, input logic bad_par, input logic [1:0] low_stop);
    logic p;
    p = cfg.par_odd ^ bad_par;
    @(posedge clk);
    put(1'b0);
    for (int i = 0; i < (cfg.nine ? 9 : 8); i++) begin
      put(w[i]);
      p = p ^ w[i];
    end
    if (cfg.par_en)
      put(p);
    put(~low_stop[0]);
    if (cfg.two_stop)
      put(~low_stop[1]);
    // Idle line stays high between frames
    rx_line <= 1'b1;
  endtask : send
endmodule : urxw_serial_src

// >>> verilog/urxw_frame.sv
// Oversampling frame receiver: start, data, parity and stop bits with error capture
`timescale 1ns/1ns
`include "urxw_regs.svh"
module urxw_frame import urxw_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic rx,
  input urxw_cfg_t cfg,
  input wire logic [7:0] divisor,
  output urxw_word_t word_r,
  output logic done_r,
  output logic idle_r
);
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  urxw_state_t st_r, st_nxt;
  logic [7:0] div_r;
  logic [3:0] phase_r, phase_nxt, idx_r, idx_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic [2:0] smp_r, smp_nxt;
  logic par_r, par_nxt, nf_r, nf_nxt, fe_r, fe_nxt, pe_r, pe_nxt, fin;

  wire tick = run && (div_r == divisor);
  wire at_end = tick && (phase_r == `URXW_OVS_LAST);
  wire maj = maj3(smp_r);
  wire noisy = (smp_r != 3'b000) && (smp_r != 3'b111);
  wire [3:0] last_idx = cfg.nine ? `URXW_LAST9 : `URXW_LAST8;
  wire [8:0] data_out = cfg.nine ? sh_nxt : {1'b0, sh_nxt[8:1]};

  always_comb begin
    st_nxt = st_r;
    phase_nxt = phase_r;
    idx_nxt = idx_r;
    sh_nxt = sh_r;
    smp_nxt = smp_r;
    par_nxt = par_r;
    nf_nxt = nf_r;
    fe_nxt = fe_r;
    pe_nxt = pe_r;
    fin = 1'b0;
    if (tick && st_r != URXW_IDLE && st_r != URXW_BRKW) begin
      phase_nxt = phase_r + 4'h1;
      if (phase_r == `URXW_SMP_A) smp_nxt[0] = rx;
      if (phase_r == `URXW_SMP_B) smp_nxt[1] = rx;
      if (phase_r == `URXW_SMP_C) smp_nxt[2] = rx;
    end
    if (at_end) nf_nxt = nf_r | noisy;
    case (st_r)
      URXW_IDLE: if (tick && !rx) begin
        st_nxt = URXW_START;
        phase_nxt = 4'h0;
        idx_nxt = 4'h0;
        par_nxt = 1'b0;
        nf_nxt = 1'b0;
        fe_nxt = 1'b0;
        pe_nxt = 1'b0;
      end
      URXW_START: if (at_end) st_nxt = maj ? URXW_IDLE : URXW_DATA;
      URXW_DATA: if (at_end) begin
        sh_nxt = {maj, sh_r[8:1]};
        par_nxt = par_r ^ maj;
        idx_nxt = idx_r + 4'h1;
        if (idx_r == last_idx) st_nxt = cfg.par_en ? URXW_PAR : URXW_STOP1;
      end
      URXW_PAR: if (at_end) begin
        pe_nxt = (par_r ^ maj) != cfg.par_odd;
        st_nxt = URXW_STOP1;
      end
      URXW_STOP1: if (at_end) begin
        fe_nxt = !maj;
        if (cfg.two_stop) st_nxt = URXW_STOP2;
        else fin = 1'b1;
      end
      URXW_STOP2: if (at_end) begin
        fe_nxt = fe_r | !maj;
        fin = 1'b1;
      end
      // The break wait is frozen too while the port clock is off
      URXW_BRKW: if (run && rx) st_nxt = URXW_IDLE;
      default: st_nxt = URXW_IDLE;
    endcase
    // A low stop bit may be a break: wait for the line to rise before hunting a start
    if (fin) st_nxt = fe_nxt ? URXW_BRKW : URXW_IDLE;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= URXW_IDLE;
      div_r <= 8'h00;
      phase_r <= 4'h0;
      idx_r <= 4'h0;
      sh_r <= 9'h000;
      smp_r <= 3'h7;
      {par_r, nf_r, fe_r, pe_r} <= 4'h0;
      done_r <= 1'b0;
      word_r <= '0;
      idle_r <= 1'b1;
    end else begin
      if (run) div_r <= tick ? 8'h00 : div_r + 8'h01;
      st_r <= st_nxt;
      phase_r <= phase_nxt;
      idx_r <= idx_nxt;
      sh_r <= sh_nxt;
      smp_r <= smp_nxt;
      {par_r, nf_r, fe_r, pe_r} <= {par_nxt, nf_nxt, fe_nxt, pe_nxt};
      done_r <= fin;
      if (fin) word_r <= '{data: data_out, ferr: fe_nxt, perr: pe_nxt, nf: nf_nxt};
      idle_r <= (st_nxt == URXW_IDLE);
    end
  end

  stop_one_low_a: assert property (@(posedge clk) disable iff (reset)
    st_r == URXW_STOP1 && at_end && !maj && !cfg.two_stop |=> done_r && word_r.ferr)
    else $error("low stop bit not flagged as framing error");
  stop_two_low_a: assert property (@(posedge clk) disable iff (reset)
    st_r == URXW_STOP2 && at_end && !maj |=> done_r && word_r.ferr)
    else $error("low second stop bit not flagged");
  parity_skip_a: assert property (@(posedge clk) disable iff (reset)
    st_r == URXW_DATA && at_end && idx_r == last_idx && !cfg.par_en |=> st_r == URXW_STOP1)
    else $error("parity bit checked while parity disabled");
endmodule : urxw_frame

// >>> verilog/urxw_pkg.sv
// Types shared by the serial receive error, interrupt and wake block
package urxw_pkg;
  typedef enum logic [2:0] {
    URXW_IDLE = 3'b000,
    URXW_START = 3'b001,
    URXW_DATA = 3'b010,
    URXW_PAR = 3'b011,
    URXW_STOP1 = 3'b100,
    URXW_STOP2 = 3'b101,
    URXW_BRKW = 3'b110
  } urxw_state_t;
  typedef struct packed {
    logic nine;
    logic par_en;
    logic par_odd;
    logic two_stop;
  } urxw_cfg_t;
  typedef struct packed {
    logic [8:0] data;
    logic ferr;
    logic perr;
    logic nf;
  } urxw_word_t;
  typedef struct packed {
    logic rx_idle;
    logic framing_error_flag;
    logic parity_error_flag;
    logic noise_flag;
    logic overrun_flag;
    logic rx_available_flag;
  } urxw_status_t;
endpackage : urxw_pkg

// >>> verilog/urxw_regs.svh
// Timing counts and field constants of the serial receive error, interrupt and wake block
`ifndef URXW_REGS_SVH
`define URXW_REGS_SVH
`define URXW_CLK_NS 4
`define URXW_STARTUP_NS 4096
`define URXW_STARTUP_CYC ((`URXW_STARTUP_NS + `URXW_CLK_NS - 1) / `URXW_CLK_NS)
`define URXW_OVS_LAST 4'hf
`define URXW_SMP_A 4'h7
`define URXW_SMP_B 4'h8
`define URXW_SMP_C 4'h9
`define URXW_LAST8 4'h7
`define URXW_LAST9 4'h8
`define URXW_DEPTH 2'h2
`endif

// >>> verilog/urxw_top.sv
// Serial receive error flags, two-word receive buffer, interrupt gating and receive-line wake
//
// Notes on behaviour
// - Framing error flag sets when a stop bit samples low.
// - With two stop bits both must be high, else framing error.
// - Framing error stored with its word; cleared by any reset.
// - Parity error only when parity enabled; odd or even selectable; reset clears.
// - Interrupt request is a low pulse for any of six port conditions.
// - Each transmit condition has its own enable; receive conditions other than address detect share one.
// - Address detect raises the interrupt without a flag, when enabled.
// - Receive falling edge with clock stopped wakes, given all five enables.
// - Status flags are read-only and clear only by defined port actions.
// - Core sees interrupt only with global, unit enables and stack not full.
// - With address detect, receive interrupt only if top received bit high.
// - Without address detect, every received word gives a receive interrupt.
// - Stopped port clock freezes reception; it resumes when clock returns.
// - Idle or sleep leaves status, control, data and divisor untouched.
// - Receive line bits during oscillator start-up are discarded.
// - Without global or unit enable, the edge only wakes the system.
// - Wake interrupt is withheld until the start-up interval has passed.
// - Receive-available clears only after status access then data read.
// - Overrun also raises the interrupt when receive interrupt enabled.
// - Noise flag clears on status read followed by data read.
`timescale 1ns/1ns
`include "urxw_regs.svh"
module urxw_top import urxw_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic port_clk_on,
  input wire logic rx_pin,
  input wire logic port_mode_select,
  input wire logic port_enable_bit,
  input wire logic receiver_enable,
  input urxw_cfg_t serial_control_one,
  input wire logic addr_detect_enable,
  input wire logic rx_wake_enable,
  input wire logic rx_irq_enable,
  input wire logic tx_empty_irq_enable,
  input wire logic tx_idle_irq_enable,
  input wire logic tx_empty,
  input wire logic tx_idle,
  input wire logic global_irq_enable,
  input wire logic serial_unit_irq_enable,
  input wire logic stack_full,
  input wire logic [7:0] baud_divisor_reg,
  input wire logic status_access,
  input wire logic data_read,
  output urxw_status_t serial_status_reg,
  output logic [8:0] tx_rx_data_reg,
  output logic irq_pulse_n,
  output logic core_irq,
  output logic wake_req
);
  // Receive buffer, two words deep
  urxw_word_t mem_r [0:1];
  logic wr_ptr_r, rd_ptr_r;
  logic [1:0] cnt_r;
  logic overrun_r, armed_r;
  logic txe_prev_r, txi_prev_r, rx_prev_r, clk_on_prev_r;
  logic wake_pend_r;
  logic [15:0] startup_cnt_r;

  urxw_word_t fr_word;
  logic fr_done, fr_idle;

  // Frame engine runs only with the port clock on and outside the start-up window
  wire startup_busy = (startup_cnt_r != 16'h0000);
  wire port_on = port_mode_select && port_enable_bit && receiver_enable;
  wire fr_run = port_clk_on && port_on && !startup_busy;

  urxw_frame u_frame (
    .clk(clk),
    .reset(reset),
    .run(fr_run),
    .rx(rx_pin),
    .cfg(serial_control_one),
    .divisor(baud_divisor_reg),
    .word_r(fr_word),
    .done_r(fr_done),
    .idle_r(fr_idle)
  );

  // Software accesses are only seen while the port clock runs
  wire acc_ok = port_clk_on;
  wire stat_hit = status_access && acc_ok;
  wire read_hit = data_read && acc_ok;
  wire full = (cnt_r == `URXW_DEPTH);
  wire pop = read_hit && armed_r && (cnt_r != 2'h0);
  wire push = fr_done && (!full || pop);
  // A third word with both slots held is dropped and the buffer kept intact
  wire ovr_set = fr_done && full && !pop;

  wire push_msb = serial_control_one.nine ? fr_word.data[8] : fr_word.data[7];
  wire rx_ev = push && rx_irq_enable && (!addr_detect_enable || push_msb);
  wire addr_ev = push && addr_detect_enable && push_msb;
  wire ovr_ev = ovr_set && rx_irq_enable;
  wire txe_ev = tx_empty && tx_empty_irq_enable && !txe_prev_r;
  wire txi_ev = tx_idle && tx_idle_irq_enable && !txi_prev_r;

  // Wake path
  wire wake_arm = rx_wake_enable && port_on && rx_irq_enable;
  wire rx_fall = rx_prev_r && !rx_pin;
  wire wake_edge = !port_clk_on && wake_arm && rx_fall;
  wire clk_back = port_clk_on && !clk_on_prev_r;
  // Gated by the port clock: a clock stop late in start-up holds the count at one
  wire wake_ev = port_clk_on && (startup_cnt_r == 16'h0001);

  wire any_ev = rx_ev || addr_ev || ovr_ev || txe_ev || txi_ev || wake_ev;
  wire core_gate = global_irq_enable && serial_unit_irq_enable && !stack_full;

  wire [1:0] cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  wire rd_ptr_nxt = rd_ptr_r ^ pop;
  urxw_word_t head;
  // A word written into the slot that becomes the head is shown at once, not one cycle stale
  assign head = (push && (rd_ptr_nxt == wr_ptr_r)) ? fr_word : mem_r[rd_ptr_nxt];
  wire have_nxt = (cnt_nxt != 2'h0);
  // No overrun can land on the clearing read: the arriving word is stored and the clear goes through
  wire overrun_nxt = ovr_set || (overrun_r && !pop);

  urxw_status_t status_nxt;
  assign status_nxt = '{
    rx_idle: fr_idle,
    framing_error_flag: have_nxt && head.ferr,
    parity_error_flag: have_nxt && head.perr,
    noise_flag: have_nxt && head.nf,
    overrun_flag: overrun_nxt,
    rx_available_flag: have_nxt
  };

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else if (push) begin
      mem_r[wr_ptr_r] <= fr_word;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
      overrun_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      overrun_r <= overrun_nxt;
      // A status access arms the next data read to clear the flags
      armed_r <= stat_hit || (armed_r && !read_hit);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_status_reg <= '{rx_idle: 1'b1, default: 1'b0};
      tx_rx_data_reg <= 9'h000;
    end else begin
      serial_status_reg <= status_nxt;
      tx_rx_data_reg <= have_nxt ? head.data : 9'h000;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txe_prev_r <= 1'b0;
      txi_prev_r <= 1'b0;
      rx_prev_r <= 1'b1;
      clk_on_prev_r <= 1'b1;
    end else begin
      txe_prev_r <= tx_empty && tx_empty_irq_enable;
      txi_prev_r <= tx_idle && tx_idle_irq_enable;
      rx_prev_r <= rx_pin;
      clk_on_prev_r <= port_clk_on;
    end
  end

  // The start-up window only opens after a wake, so normal clock gating costs nothing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_pend_r <= 1'b0;
      startup_cnt_r <= 16'h0000;
      wake_req <= 1'b0;
    end else begin
      wake_req <= wake_edge;
      if (wake_edge) wake_pend_r <= 1'b1;
      else if (wake_ev) wake_pend_r <= 1'b0;
      if (clk_back && (wake_pend_r || wake_edge)) startup_cnt_r <= 16'(`URXW_STARTUP_CYC);
      else if (startup_busy && port_clk_on) startup_cnt_r <= startup_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_pulse_n <= 1'b1;
      core_irq <= 1'b0;
    end else begin
      irq_pulse_n <= !any_ev;
      core_irq <= any_ev && core_gate;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence startup_end_s;
    startup_busy && port_clk_on ##1 startup_cnt_r == 16'h0001 && port_clk_on;
  endsequence

  rx_pulse_low_a: assert property (rx_ev |=> !irq_pulse_n)
    else $error("received word gave no low interrupt pulse");
  addr_gate_a: assert property (push && addr_detect_enable && !push_msb && !txe_ev && !txi_ev && !wake_ev |=> irq_pulse_n)
    else $error("data word raised receive interrupt in address mode");
  addr_off_a: assert property (push && !addr_detect_enable && rx_irq_enable |=> !irq_pulse_n)
    else $error("receive interrupt missed with address detect off");
  addr_event_a: assert property (push && addr_detect_enable && push_msb |=> !irq_pulse_n)
    else $error("address word gave no interrupt");
  overrun_irq_a: assert property (ovr_set && rx_irq_enable |=> !irq_pulse_n && serial_status_reg.overrun_flag)
    else $error("overrun gave no interrupt");
  core_gate_a: assert property (core_irq |-> $past(global_irq_enable && serial_unit_irq_enable && !stack_full))
    else $error("core interrupt without enables");
  core_block_a: assert property (!global_irq_enable && any_ev |=> !core_irq)
    else $error("interrupt reached core with global enable clear");
  avail_hold_a: assert property (cnt_r != 2'h0 && !pop |=> serial_status_reg.rx_available_flag)
    else $error("receive-available flag cleared without read sequence");
  overrun_hold_a: assert property (overrun_r && !pop |=> overrun_r)
    else $error("overrun flag cleared without read sequence");
  startup_mute_a: assert property (startup_busy |=> !fr_done && $stable(fr_idle))
    else $error("receiver ran during start-up interval");
  data_store_a: assert property (push && cnt_r == 2'h0 |=> tx_rx_data_reg == $past(fr_word.data) && serial_status_reg.framing_error_flag == $past(fr_word.ferr))
    else $error("stored word not shown with its flags");
  wake_after_a: assert property (startup_end_s |=> !irq_pulse_n)
    else $error("wake interrupt not given after start-up");
  freeze_a: assert property (!port_clk_on && !fr_done |=> $stable(cnt_r) && $stable(overrun_r))
    else $error("buffer state changed with port clock off");
  wake_edge_a: assert property (!port_clk_on && wake_arm && rx_fall |=> wake_req ##1 wake_pend_r)
    else $error("falling edge with clock stopped did not wake");
endmodule : urxw_top
